// ### inc/mact_pkg.sv
package mact_pkg;

   // =========================================================
   // Encoded lengths in bytes
   // =========================================================
   localparam logic [1:0] LEN_ONE   = 2'h1;
   localparam logic [1:0] LEN_TWO   = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;

   // =========================================================
   // Execution cycle counts
   // =========================================================
   localparam logic [2:0] CYC_MOV_A_REG    = 3'h1;
   localparam logic [2:0] CYC_MOV_A_DIR    = 3'h2;
   localparam logic [2:0] CYC_MOV_A_IND    = 3'h2;
   localparam logic [2:0] CYC_MOV_A_IMM    = 3'h2;
   localparam logic [2:0] CYC_MOV_REG_A    = 3'h2;
   localparam logic [2:0] CYC_MOV_REG_DIR  = 3'h4;
   localparam logic [2:0] CYC_MOV_REG_IMM  = 3'h2;
   localparam logic [2:0] CYC_MOV_DIR_SRC  = 3'h3;
   localparam logic [2:0] CYC_MOV_DIR_DIR  = 3'h4;
   localparam logic [2:0] CYC_MOV_DIR_IND  = 3'h4;
   localparam logic [2:0] CYC_MOV_DIR_IMM  = 3'h3;
   localparam logic [2:0] CYC_MOV_IND_DST  = 3'h3;
   localparam logic [2:0] CYC_LOAD_PTR     = 3'h3;
   localparam logic [2:0] CYC_CODE_LOAD    = 3'h4;
   localparam logic [2:0] CYC_AUX_RAM      = 3'h3;
   localparam logic [2:0] CYC_PUSH         = 3'h4;
   localparam logic [2:0] CYC_POP          = 3'h3;
   localparam logic [2:0] CYC_XCH_REG      = 3'h3;
   localparam logic [2:0] CYC_XCH_DIR      = 3'h4;
   localparam logic [2:0] CYC_XCH_IND      = 3'h4;
   localparam logic [2:0] CYC_ARITH_REG    = 3'h2;
   localparam logic [2:0] CYC_ARITH_MEM    = 3'h3;
   localparam logic [2:0] CYC_ARITH_IMM    = 3'h2;
   localparam logic [2:0] CYC_INC_REG      = 3'h3;
   localparam logic [2:0] CYC_INC_MEM      = 3'h4;
   localparam logic [2:0] CYC_UNKNOWN      = 3'h1;
   localparam logic [2:0] CYC_INC_ACC_DFLT = 3'h1;

   // =========================================================
   // Types
   // =========================================================
   typedef enum logic [2:0] {
      ALU_NONE = 3'h0,
      ALU_ADD  = 3'h1,
      ALU_ADD_WITH_CARRY = 3'h2,
      ALU_SUBTRACT_WITH_BORROW = 3'h3,
      ALU_INC  = 3'h4
   } mact_alu_e;

   typedef struct packed {
      logic       known;
      logic [1:0] len;
      logic [2:0] cyc;
      mact_alu_e  alu;
   } mact_dec_s;

   typedef struct packed {
      logic [7:0] result;
      logic       cy;
      logic       ac;
      logic       ov;
   } mact_flags_s;

endpackage

// ### verilog/mact_decode.sv
`timescale 1ns/1ps
module mact_decode #(
   parameter logic [2:0] INC_ACC_CYCLES = mact_pkg::CYC_INC_ACC_DFLT
) (
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       OPC_VALID,
   input  wire logic [7:0] OPC,
   input  wire logic [7:0] ACC,
   input  wire logic [7:0] OPERAND,
   input  wire logic       CARRY_IN,
   output logic            READY,
   output logic            BUSY,
   output logic            DONE,
   output logic            KNOWN,
   output logic [1:0]      LEN,
   output logic [2:0]      CYCLES,
   output logic            ARITH_VALID,
   output logic [7:0]      RESULT,
   output logic            CY,
   output logic            AC,
   output logic            OV
);

   // =========================================================
   // Elaboration check
   // =========================================================
   // A zero count would end the increment at the edge that takes it, so the
   // decoder would never report it busy and DONE would never pulse for it.
   if (INC_ACC_CYCLES == 3'h0) begin : g_bad_inc
      $error("INC_ACC_CYCLES must be at least one");
   end

   // =========================================================
   // Opcode decode
   // =========================================================
   // Opcodes outside the decoded set report one byte and one cycle, so a fetch unit
   // that ignores KNOWN still steps past them instead of stalling.
   function automatic mact_pkg::mact_dec_s decode(input logic [7:0] op);
      mact_pkg::mact_dec_s d;
      d.known = 1'b1;
      d.len   = mact_pkg::LEN_ONE;
      d.cyc   = mact_pkg::CYC_UNKNOWN;
      d.alu   = mact_pkg::ALU_NONE;
      casez (op)
         8'b1110_1???: begin
            d.cyc = mact_pkg::CYC_MOV_A_REG;
         end
         8'he5: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_A_DIR;
         end
         8'b1110_011?: begin
            d.cyc = mact_pkg::CYC_MOV_A_IND;
         end
         8'h74: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_A_IMM;
         end
         8'b1111_1???: begin
            d.cyc = mact_pkg::CYC_MOV_REG_A;
         end
         8'b1010_1???: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_REG_DIR;
         end
         8'b0111_1???: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_REG_IMM;
         end
         8'hf5, 8'b1000_1???: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_DIR_SRC;
         end
         8'h85: begin
            d.len = mact_pkg::LEN_THREE;
            d.cyc = mact_pkg::CYC_MOV_DIR_DIR;
         end
         8'b1000_011?: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_DIR_IND;
         end
         8'h75: begin
            d.len = mact_pkg::LEN_THREE;
            d.cyc = mact_pkg::CYC_MOV_DIR_IMM;
         end
         8'b1111_011?: begin
            d.cyc = mact_pkg::CYC_MOV_IND_DST;
         end
         // direct or immediate to pointer RAM
         8'b1010_011?, 8'b0111_011?: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_MOV_IND_DST;
         end
         8'h90: begin
            d.len = mact_pkg::LEN_THREE;
            d.cyc = mact_pkg::CYC_LOAD_PTR;
         end
         8'h93, 8'h83: begin
            d.cyc = mact_pkg::CYC_CODE_LOAD;
         end
         8'b1110_001?, 8'he0, 8'b1111_001?, 8'hf0: begin
            d.cyc = mact_pkg::CYC_AUX_RAM;
         end
         8'hc0: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_PUSH;
         end
         8'hd0: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_POP;
         end
         8'b1100_1???: begin
            d.cyc = mact_pkg::CYC_XCH_REG;
         end
         8'hc5: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_XCH_DIR;
         end
         8'b1100_011?, 8'b1101_011?: begin
            d.cyc = mact_pkg::CYC_XCH_IND;
         end
         8'b0010_1???, 8'b0011_1???, 8'b1001_1???: begin
            d.cyc = mact_pkg::CYC_ARITH_REG;
            d.alu = alu_of(op);
         end
         8'h25, 8'h35, 8'h95: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_ARITH_MEM;
            d.alu = alu_of(op);
         end
         8'b0010_011?, 8'b0011_011?, 8'b1001_011?: begin
            d.cyc = mact_pkg::CYC_ARITH_MEM;
            d.alu = alu_of(op);
         end
         8'h24, 8'h34, 8'h94: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_ARITH_IMM;
            d.alu = alu_of(op);
         end
         8'h04: begin
            d.cyc = INC_ACC_CYCLES;
            d.alu = mact_pkg::ALU_INC;
         end
         8'b0000_1???: begin
            d.cyc = mact_pkg::CYC_INC_REG;
            d.alu = mact_pkg::ALU_INC;
         end
         8'h05: begin
            d.len = mact_pkg::LEN_TWO;
            d.cyc = mact_pkg::CYC_INC_MEM;
            d.alu = mact_pkg::ALU_INC;
         end
         8'b0000_011?: begin
            d.cyc = mact_pkg::CYC_INC_MEM;
            d.alu = mact_pkg::ALU_INC;
         end
         default: begin
            d.known = 1'b0;
         end
      endcase
      return d;
   endfunction

   function automatic mact_pkg::mact_alu_e alu_of(input logic [7:0] op);
      mact_pkg::mact_alu_e a;
      case (op[7:4])
         4'h2:    a = mact_pkg::ALU_ADD;
         4'h3:    a = mact_pkg::ALU_ADD_WITH_CARRY;
         default: a = mact_pkg::ALU_SUBTRACT_WITH_BORROW;
      endcase
      return a;
   endfunction

   // =========================================================
   // Add and subtract with flags
   // =========================================================
   // Increment leaves the flags untouched, so only the add and subtract opcodes report them.
   function automatic mact_pkg::mact_flags_s arith(input mact_pkg::mact_alu_e a,
                                                  input logic [7:0] x,
                                                  input logic [7:0] y,
                                                  input logic       cin);
      mact_pkg::mact_flags_s f;
      logic [8:0] full;
      logic [4:0] low;
      logic       c;
      c    = (a == mact_pkg::ALU_ADD) ? 1'b0 : cin;
      full = 9'h000;
      low  = 5'h00;
      if (a == mact_pkg::ALU_SUBTRACT_WITH_BORROW) begin
         full = {1'b0, x} - {1'b0, y} - {8'h00, c};
         low  = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, c};
         f.ov = (x[7] != y[7]) && (full[7] != x[7]);
      end else begin
         full = {1'b0, x} + {1'b0, y} + {8'h00, c};
         low  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, c};
         f.ov = (x[7] == y[7]) && (full[7] != x[7]);
      end
      f.result = full[7:0];
      f.cy     = full[8];
      f.ac     = low[4];
      return f;
   endfunction

   // =========================================================
   // Acceptance and cycle sequencing
   // =========================================================
   // A new opcode is taken in the last busy cycle of the previous one, so
   // instructions run back to back without a dead cycle in between.
   mact_pkg::mact_dec_s   dec;
   mact_pkg::mact_flags_s flg;
   logic [2:0]            remain_r;
   logic [2:0]            remain_nxt;
   logic                  take;
   logic                  is_arith;

   assign dec      = decode(OPC);
   assign take     = OPC_VALID && (remain_r <= 3'h1);
   assign is_arith = (dec.alu == mact_pkg::ALU_ADD) ||
                     (dec.alu == mact_pkg::ALU_ADD_WITH_CARRY) ||
                     (dec.alu == mact_pkg::ALU_SUBTRACT_WITH_BORROW);
   assign flg      = arith(dec.alu, ACC, OPERAND, CARRY_IN);

   // READY and BUSY are registered images of the next count, which keeps every
   // output on a flip-flop without adding a cycle of delay to either.
   always_comb begin
      if (take) begin
         remain_nxt = dec.cyc;
      end else if (remain_r != 3'h0) begin
         remain_nxt = remain_r - 3'h1;
      end else begin
         remain_nxt = 3'h0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         remain_r <= 3'h0;
         BUSY     <= 1'b0;
         READY    <= 1'b1;
         DONE     <= 1'b0;
      end else begin
         remain_r <= remain_nxt;
         BUSY     <= (remain_nxt != 3'h0);
         READY    <= (remain_nxt <= 3'h1);
         // The end pulse still fires when a new opcode is taken at the same edge, so
         // back-to-back instructions each report their end.
         DONE     <= (remain_r == 3'h1);
      end
   end

   // =========================================================
   // Decode results
   // =========================================================
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         KNOWN  <= 1'b0;
         LEN    <= 2'h0;
         CYCLES <= 3'h0;
      end else if (take) begin
         KNOWN  <= dec.known;
         LEN    <= dec.len;
         CYCLES <= dec.cyc;
      end
   end

   // =========================================================
   // Arithmetic results
   // =========================================================
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         ARITH_VALID <= 1'b0;
         RESULT      <= 8'h00;
         CY          <= 1'b0;
         AC          <= 1'b0;
         OV          <= 1'b0;
      end else if (take) begin
         // Flags are held across moves and increments, so a carry computed by one
         // add stays readable until the next add or subtract opcode replaces it.
         ARITH_VALID <= is_arith;
         if (is_arith) begin
            RESULT <= flg.result;
            CY     <= flg.cy;
            AC     <= flg.ac;
            OV     <= flg.ov;
         end
      end
   end

endmodule

// ### dv/mact_opc_source.sv
`timescale 1ns/1ps
// ==========================================================
// Opcode source standing in for program memory
// ==========================================================
module mact_opc_source (
   input  wire logic       clk,
   input  wire logic       ready,
   output logic            opc_valid,
   output logic [7:0]      opc,
   output logic [7:0]      acc,
   output logic [7:0]      operand,
   output logic            carry_in
);
   initial begin
      {opc_valid, opc, acc, operand, carry_in} = '0;
   end

   // The request is held unchanged until an edge that finds the decoder ready.
   task automatic issue(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b,
                        input logic c);
      int n;
      @(negedge clk);
      {opc_valid, opc, acc, operand, carry_in} = {1'b1, o, a, b, c};
      n = 0;
      while (ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
   endtask

   // Released lines flip so that a stale value cannot pass for a held one.
   task automatic drop();
      @(negedge clk);
      {opc_valid, opc, acc, operand, carry_in} = {1'b0, ~opc, ~acc, ~operand, ~carry_in};
   endtask
endmodule

// ### dv/mact_decode_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// Decode and timing checker
// ==========================================================
module mact_checker #(
   parameter logic [2:0] INC_ACC_CYCLES = mact_pkg::CYC_INC_ACC_DFLT
) (
   input  wire logic       CLK,
   input  wire logic       RST_B,
   input  wire logic       OPC_VALID,
   input  wire logic [7:0] OPC,
   input  wire logic [7:0] ACC,
   input  wire logic [7:0] OPERAND,
   input  wire logic       CARRY_IN,
   input  wire logic       READY,
   input  wire logic       BUSY,
   input  wire logic       DONE,
   input  wire logic       KNOWN,
   input  wire logic [1:0] LEN,
   input  wire logic [2:0] CYCLES,
   input  wire logic       ARITH_VALID,
   input  wire logic [7:0] RESULT,
   input  wire logic       CY,
   input  wire logic       AC,
   input  wire logic       OV
);
   logic take;
   assign take = OPC_VALID && READY;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_reg_copy: assert property (take && OPC[7:3] == 5'h1d |=>
      KNOWN && LEN == 2'h1 && CYCLES == 3'h1) else $error("register copy decode wrong");
   a_busy_span: assert property (take && OPC == 8'h85 |=> BUSY [*4] ##1 DONE)
      else $error("direct copy busy span wrong");
   a_ready_gap: assert property (take && OPC == 8'h85 |=> !READY [*3] ##1 READY)
      else $error("direct copy ready gap wrong");
   a_add_sum: assert property (take && OPC == 8'h24 |=>
      {CY, RESULT} == {1'b0, $past(ACC)} + {1'b0, $past(OPERAND)}) else $error("add wrong");
   a_subtract_with_borrow_diff: assert property (take && OPC == 8'h94 |=>
      {CY, RESULT} == {1'b0, $past(ACC)} - {1'b0, $past(OPERAND)} - $past(CARRY_IN))
      else $error("subtract wrong");
   a_flags_hold: assert property (!take |=> $stable({RESULT, CY, AC, OV}))
      else $error("flags changed without a take");
   a_inc_acc: assert property (take && OPC == 8'h04 |=>
      LEN == 2'h1 && CYCLES == INC_ACC_CYCLES && !ARITH_VALID) else $error("inc acc wrong");
   a_code_load: assert property (take && (OPC == 8'h93 || OPC == 8'h83) |=>
      LEN == 2'h1 && CYCLES == 3'h4) else $error("code load decode wrong");
   a_push_dec: assert property (take && OPC == 8'hc0 |=>
      LEN == 2'h2 && CYCLES == 3'h4) else $error("push decode wrong");
endmodule

bind mact_decode mact_checker #(.INC_ACC_CYCLES(INC_ACC_CYCLES)) mact_checker_inst (
   .CLK(CLK), .RST_B(RST_B), .OPC_VALID(OPC_VALID), .OPC(OPC), .ACC(ACC),
   .OPERAND(OPERAND), .CARRY_IN(CARRY_IN), .READY(READY), .BUSY(BUSY), .DONE(DONE),
   .KNOWN(KNOWN), .LEN(LEN), .CYCLES(CYCLES), .ARITH_VALID(ARITH_VALID),
   .RESULT(RESULT), .CY(CY), .AC(AC), .OV(OV));

// ### dv/cpu_move_arith_cycle_timing_test.sv
`timescale 1ns/1ps
// ==========================================================
// Testbench
// ==========================================================
module cpu_move_arith_cycle_timing_test;
   // A non-default increment count shows that the parameter really reaches the decode.
   localparam logic [2:0] INC_P = 3'h3;
   // Each entry is opcode, length nibble and cycle nibble.
   localparam logic [15:0] TBL [0:47] = '{
      16'he811, 16'hef11, 16'he522, 16'he612, 16'he712, 16'h7422,
      16'hf812, 16'hff12, 16'ha824, 16'h7822, 16'hf523, 16'h8823,
      16'h8534, 16'h8624, 16'h7533, 16'hf613, 16'ha623, 16'h7623,
      16'h9033, 16'h9314, 16'h8314, 16'he213, 16'he013, 16'hf213,
      16'hf013, 16'hc024, 16'hd023, 16'hc813, 16'hc524, 16'hc614,
      16'hd614, 16'h2812, 16'h3812, 16'h9812, 16'h2523, 16'h2613,
      16'h3523, 16'h3613, 16'h9523, 16'h9613, 16'h2422, 16'h3422,
      16'h9422, 16'h0813, 16'h0524, 16'h0614, {8'h04, 4'h1, 1'b0, INC_P}, 16'h5411};
   logic       clk;
   logic       rst_b;
   logic       opc_valid;
   logic [7:0] opc;
   logic [7:0] acc;
   logic [7:0] operand;
   logic       carry_in;
   logic       ready;
   logic       busy;
   logic       done;
   logic       known;
   logic [1:0] len;
   logic [2:0] cycles;
   logic       arith_valid;
   logic [7:0] result;
   logic       cy;
   logic       ac;
   logic       ov;
   int         n_errors;
   int         tests_run;
   int         cyc;

   mact_decode #(.INC_ACC_CYCLES(INC_P)) mact_decode_inst (.CLK(clk), .RST_B(rst_b),
      .OPC_VALID(opc_valid), .OPC(opc), .ACC(acc), .OPERAND(operand), .CARRY_IN(carry_in),
      .READY(ready), .BUSY(busy), .DONE(done), .KNOWN(known), .LEN(len), .CYCLES(cycles),
      .ARITH_VALID(arith_valid), .RESULT(result), .CY(cy), .AC(ac), .OV(ov));
   mact_opc_source mact_opc_source_inst (.clk(clk), .ready(ready), .opc_valid(opc_valid),
      .opc(opc), .acc(acc), .operand(operand), .carry_in(carry_in));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One opcode through take, busy span and done pulse.
   task automatic run_op(input logic [15:0] e, input logic [7:0] a, input logic [7:0] b,
                         input logic c);
      int n;
      mact_opc_source_inst.issue(e[15:8], a, b, c);
      mact_opc_source_inst.drop();
      #1;
      check("known", known, e[15:8] != 8'h54);
      check("len", len, e[5:4]);
      check("cycles", cycles, e[2:0]);
      n = 0;
      while (busy === 1'b1 && n < 9) begin
         @(negedge clk);
         #1;
         n++;
      end
      check("busy span", 16'(n), e[2:0]);
      check("done", done, 1'b1);
   endtask

   task automatic t_table();
      for (int i = 0; i < 48; i++) begin
         run_op(TBL[i], 8'h00, 8'h00, 1'b0);
      end
   endtask

   // A second request held while busy is taken at the edge ending the last busy cycle.
   task automatic t_back();
      time t0;
      mact_opc_source_inst.issue(8'h85, 8'h00, 8'h00, 1'b0);
      t0 = $time;
      fork
         mact_opc_source_inst.issue(8'he8, 8'h00, 8'h00, 1'b0);
         begin
            repeat (2) @(negedge clk);
            #1;
            check("held len", len, 2'h3);
         end
      join
      check("take gap", 16'($time - t0), 16'd40);
      mact_opc_source_inst.drop();
      #1;
      check("second len", {len, cycles}, {2'h1, 3'h1});
      @(negedge clk);
   endtask

   task automatic arith(input logic [15:0] e, input logic [7:0] a, input logic [7:0] b,
                        input logic c, input logic [10:0] x);
      run_op(e, a, b, c);
      check("flags", {cy, ac, ov, result}, x);
      check("arith valid", arith_valid, 1'b1);
   endtask

   task automatic t_arith();
      arith(16'h2422, 8'h7f, 8'h01, 1'b1, 11'h380);
      arith(16'h3422, 8'hff, 8'h00, 1'b1, 11'h600);
      arith(16'h3812, 8'h0f, 8'h01, 1'b0, 11'h210);
      arith(16'h9422, 8'h00, 8'h01, 1'b0, 11'h6ff);
      arith(16'h2613, 8'h10, 8'h20, 1'b0, 11'h030);
      arith(16'h9523, 8'h80, 8'h01, 1'b1, 11'h37e);
      run_op(TBL[46], 8'h55, 8'h66, 1'b0);
      check("inc flags", {cy, ac, ov, result, arith_valid}, 12'h6fc);
   endtask

   task automatic t_midreset();
      mact_opc_source_inst.issue(8'h85, 8'h00, 8'h00, 1'b0);
      mact_opc_source_inst.drop();
      rst_b = 1'b0;
      #1;
      check("mid reset", {ready, busy, known, len, cycles}, 8'h80);
      @(negedge clk);
      rst_b = 1'b1;
      run_op(TBL[0], 8'h00, 8'h00, 1'b0);
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      rst_b = 1'b0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      #1;
      check("reset", {ready, busy, done, known, len, cycles, arith_valid, cy, ac, ov}, 13'h1000);
      check("reset result", result, 8'h00);
      t_table();
      t_back();
      t_arith();
      t_midreset();
      finish_test();
   end
endmodule
